/* File: include/aotc_pkg.sv */
// package: register map, field layout and carrier types of the amp trim block
package aotc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  // printed offset is not word aligned: it is kept as an index
  localparam logic [7:0]  CTRL_INDEX     = 8'h1f;
  localparam logic [11:0] CTRL_ADDR      = {2'b00, CTRL_INDEX, 2'b00};
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  CTRL_WR_MASK   = 8'hbf;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int TRIM_LSB   = 0;
  localparam int TRIM_W     = 4;
  localparam int REF_BIT    = 4;
  localparam int CANCEL_BIT = 5;
  localparam int STATE_BIT  = 6;
  localparam int ENABLE_BIT = 7;

  // ****************************************************************
  // configuration option
  // ****************************************************************
  localparam logic OPT_COMPARATOR = 1'b0;
  localparam logic OPT_OPAMP      = 1'b1;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic                    amp_power_enable;
    logic                    cancel_mode_select;
    logic                    reference_input_select;
    logic [TRIM_W-1:0]       offset_trim_code;
  } aotc_ctrl_type;

  typedef struct packed {
    logic                    opamp_mode;
    logic                    amp_power_enable;
    logic                    amp_output_oe;
    logic                    cancel_mode;
    logic                    common_mode_switch;
    logic                    reference_switch_a;
    logic                    reference_switch_b;
    logic [TRIM_W-1:0]       offset_trim_code;
  } aotc_analog_type;

endpackage

/* File: logic/aotc_reg.sv */
// module: parameterised register stage with clock enable and reset value
`timescale 1ns/1ps
module aotc_reg #(
  parameter int          W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  // clock, reset and clock enable
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST;
    end else if (ce) begin
      q <= d;
    end
  end

endmodule

/* File: logic/aotc_top.sv */
// module: control register and switch steering of the amp/comparator
//
// Operation
// RULE1: cancel mode bit 5 set gives offset cancellation, clear gives normal use.
// RULE2: cancel mode closes the common mode switch and one reference switch.
// RULE3: bit 4 set picks the noninverting input as reference, clear the inverting.
// RULE4: bits 3..0 are the trim code driven to the offset adjust.
// RULE5: bit 6 reads the live output state, high output reads one.
// RULE6: bit 7 powers the amplifier; cleared, output is left floating.
// RULE7: software calibrates by stepping trim in cancel mode until output flips.
// RULE8: software then clears cancel mode and keeps the trim code.
// RULE9: a strap fixed at programming picks op amp or comparator, comparator default.
// RULE10: software should clear enable before power down.
// RULE11: bit 6 ignores writes, the other bits read back as written.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module aotc_top #(
  parameter int AW = 12
) (
  // clock, reset, enable
  input  wire logic          mclk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // configuration strap
  input  wire logic          opt_opamp_sel,
  // analog side
  input  wire logic          amp_output_in,
  output aotc_pkg::aotc_analog_type analog
);

  // ****************************************************************
  // state
  // ****************************************************************
  aotc_pkg::aotc_ctrl_type ctrl_r;
  aotc_pkg::aotc_ctrl_type ctrl_nxt;
  logic                    state_r;
  logic                    state_nxt;
  logic                    opamp_r;
  logic                    opamp_nxt;
  logic                    strap_done_r;
  logic                    strap_done_nxt;
  logic [31:0]             prdata_r;
  logic [31:0]             prdata_nxt;
  logic                    pready_r;
  logic                    pready_nxt;
  logic                    pslverr_r;
  logic                    pslverr_nxt;
  logic                    hit;
  logic                    wr_take;
  logic [7:0]              rd_byte;
  logic [7:0]              wr_byte;
  logic                    cancel_on;
  logic                    ref_noninv;
  aotc_pkg::aotc_analog_type analog_nxt;

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ****************************************************************
  // register decode
  // ****************************************************************
  always_comb begin
    hit     = (paddr == AW'(aotc_pkg::CTRL_ADDR));
    wr_take = psel && penable && pready_r && pwrite && hit && pstrb[0];
    rd_byte = {ctrl_r.amp_power_enable, state_r,
               ctrl_r.cancel_mode_select, ctrl_r.reference_input_select,
               ctrl_r.offset_trim_code};
    // status bit is dropped from the write image
    wr_byte = pwdata[7:0] & aotc_pkg::CTRL_WR_MASK; // [RULE11]
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_take) begin
      ctrl_nxt.amp_power_enable       = wr_byte[aotc_pkg::ENABLE_BIT];
      ctrl_nxt.cancel_mode_select     = wr_byte[aotc_pkg::CANCEL_BIT];
      ctrl_nxt.reference_input_select = wr_byte[aotc_pkg::REF_BIT];
      ctrl_nxt.offset_trim_code       =
        wr_byte[aotc_pkg::TRIM_LSB +: aotc_pkg::TRIM_W]; // [RULE4]
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= aotc_pkg::aotc_ctrl_type'(aotc_pkg::CTRL_RESET[6:0]);
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ****************************************************************
  // output status sample
  // ****************************************************************
  // a floating output of a disabled amp reads as low; the pin is taken
  // as synchronous, so no extra stage is spent on it
  always_comb begin
    state_nxt = amp_output_in && ctrl_r.amp_power_enable; // [RULE5] [RULE6]
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // configuration strap
  // ****************************************************************
  // the strap is caught once at the first enabled edge after reset,
  // never through the reset itself
  always_comb begin
    strap_done_nxt = 1'b1;
    opamp_nxt      = strap_done_r ? opamp_r : opt_opamp_sel; // [RULE9]
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_r <= 1'b0;
      opamp_r      <= aotc_pkg::OPT_COMPARATOR; // [RULE9]
    end else if (ce) begin
      strap_done_r <= strap_done_nxt;
      opamp_r      <= opamp_nxt;
    end
  end

  // ****************************************************************
  // apb slave: one wait-free access phase after every setup
  // ****************************************************************
  always_comb begin
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    if (psel && !penable) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !hit;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // read image is caught at the setup edge and held until the next
  // setup, so a slow master still sees stable data
  always_comb begin
    prdata_nxt = prdata_r;
    if (psel && !penable) begin
      prdata_nxt = (hit && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h00000000;
    end else if (ce) begin
      prdata_r <= prdata_nxt;
    end
  end

  // ****************************************************************
  // analog steering
  // ****************************************************************
  // switches follow the mode and reference bits, not the enable, so a calibration
  // can be set up before the amp is powered
  always_comb begin
    cancel_on  = ctrl_r.cancel_mode_select; // [RULE1]
    ref_noninv = ctrl_r.reference_input_select; // [RULE3]
  end

  always_comb begin
    analog_nxt.opamp_mode         = opamp_r; // [RULE9]
    analog_nxt.amp_power_enable   = ctrl_r.amp_power_enable; // [RULE6]
    analog_nxt.amp_output_oe      = ctrl_r.amp_power_enable; // [RULE6]
    analog_nxt.cancel_mode        = cancel_on; // [RULE1]
    analog_nxt.common_mode_switch = cancel_on; // [RULE2]
    analog_nxt.reference_switch_a = cancel_on && ref_noninv; // [RULE3]
    analog_nxt.reference_switch_b = cancel_on && !ref_noninv; // [RULE3]
    analog_nxt.offset_trim_code   = ctrl_r.offset_trim_code; // [RULE4]
  end

  // outputs leave through a flop so the switches never glitch on decode
  aotc_reg #(
    .W   ($bits(aotc_pkg::aotc_analog_type)),
    .RST ('0)
  ) i_aotc_reg (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     (analog_nxt),
    .q     (analog)
  );

endmodule

/* File: tb/aotc_chk.sv */
// checker: concurrent properties of the amp trim control block
`timescale 1ns/1ps
module aotc_chk (
  // clock and reset
  input wire logic                      mclk,
  input wire logic                      rst_n,
  // apb
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [11:0]               paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [3:0]                pstrb,
  input wire logic                      pready,
  input wire logic                      pslverr,
  // strap and analog side
  input wire logic                      opt_opamp_sel,
  input wire aotc_pkg::aotc_analog_type analog
);
  // ********
  // helpers
  // ********
  logic wr;
  assign wr = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ********
  // properties
  // ********
  // analog lags the control write by one extra edge
  property p_trim;
    wr |=> ##1 analog.offset_trim_code == $past(pwdata[3:0], 2);
  endproperty
  a_trim: assert property (p_trim) else $error("trim code wrong");
  property p_cancel;
    wr |=> ##1 analog.cancel_mode == $past(pwdata[5], 2);
  endproperty
  a_cancel: assert property (p_cancel) else $error("mode wrong");
  property p_ref;
    wr |=> ##1 analog.reference_switch_a ==
      ($past(pwdata[5], 2) && $past(pwdata[4], 2));
  endproperty
  a_ref: assert property (p_ref) else $error("reference wrong");
  property p_sw;
    analog.cancel_mode == analog.common_mode_switch && analog.cancel_mode
      == (analog.reference_switch_a ^ analog.reference_switch_b);
  endproperty
  a_sw: assert property (p_sw) else $error("switches wrong");
  property p_en;
    wr |=> ##1 {analog.amp_output_oe, analog.amp_power_enable} ==
      {2{$past(pwdata[7], 2)}};
  endproperty
  a_en: assert property (p_en) else $error("enable wrong");
  property p_mode;
    rst_n && $past(rst_n, 2) |-> analog.opamp_mode == opt_opamp_sel;
  endproperty
  a_mode: assert property (p_mode) else $error("strap wrong");
  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready wrong");
  property p_err;
    psel && !penable && paddr != aotc_pkg::CTRL_ADDR |=> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no slave error");
endmodule

bind aotc_top aotc_chk i_aotc_chk (.mclk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .pready, .pslverr, .opt_opamp_sel, .analog);

/* File: tb/aotc_top_bench.sv */
// testbench: register access and analog steering of the amp trim block
`timescale 1ns/1ps
module aotc_top_bench;
  logic                      mclk, rst_n, psel, penable, pwrite, er;
  logic                      opt_opamp_sel, amp_output_in, pready, pslverr;
  logic [11:0]               paddr;
  logic [31:0]               pwdata, prdata;
  logic [3:0]                pstrb;
  logic [7:0]                rd;
  aotc_pkg::aotc_analog_type analog;
  int                        fail_count = 0;
  int                        check_count = 0;
  localparam logic [11:0]    A = aotc_pkg::CTRL_ADDR;

  // ce tied high: freezing is not exercised here
  aotc_top i_aotc_top (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .opt_opamp_sel(opt_opamp_sel), .amp_output_in(amp_output_in),
    .analog(analog));

  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  // ********
  // tasks
  // ********
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d, input logic s);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= {4{s}};
    @(posedge mclk);
    penable <= 1;
    // look at the answer mid-cycle, then complete on the next rising edge
    @(negedge mclk);
    while (pready !== 1'b1 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    if (n == 8) chk(0, 1);
    rd = prdata[7:0];
    er = pslverr;
    @(posedge mclk);
    psel <= 0;
    penable <= 0;
  endtask
  // write, read back, then compare the switch image
  task automatic wrrd(input logic [7:0] d, input logic [7:0] e);
    xfer(1, A, d, 1);
    xfer(0, A, 0, 1);
    chk(rd, e);
    chk(analog, {opt_opamp_sel, e[7], e[7], e[5], e[5], e[5] & e[4],
                 e[5] & ~e[4], e[3:0]});
  endtask
  // ********
  // tests
  // ********
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {rst_n, opt_opamp_sel, amp_output_in} = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1;
    xfer(0, A, 0, 1);
    chk(rd, 8'h00);
    // calibration sweep: output flips once trim passes 8
    for (int t = 0; t < 16; t++) begin
      amp_output_in <= (t > 8);
      wrrd(8'hb0 | t[7:0], 8'hb0 | t[7:0] | {t > 8, 6'h0});
    end
    amp_output_in <= 0;
    wrrd(8'hff, 8'hbf);
    wrrd(8'h89, 8'h89);
    amp_output_in <= 1;
    wrrd(8'h09, 8'h09);
    wrrd(8'ha0, 8'he0);
    xfer(1, A, 8'h55, 0);
    xfer(0, A + 12'h4, 0, 1);
    chk({er, rd}, 9'h100);
    xfer(0, A, 0, 1);
    chk(rd, 8'he0);
    wrrd(8'h60, 8'h20);
    rst_n <= 0;
    opt_opamp_sel <= 1;
    repeat (6) @(posedge mclk);
    rst_n <= 1;
    repeat (4) @(posedge mclk);
    chk(analog, 11'h400);
    complete_run();
  end
  initial begin
    #100us;
    fail_count++;
    complete_run();
  end
endmodule
